// ---- hw/gsp_regs.vh ----
// constants for the bus talker and serial poll interface
`ifndef GSP_REGS_VH
`define GSP_REGS_VH
// ********************************************
// multiline bus commands (7 bit, parity ignored)
// ********************************************
`define GSP_CMD_UNL 7'h3f
`define GSP_CMD_UNT 7'h5f
`define GSP_CMD_SPE 7'h18
`define GSP_CMD_SPD 7'h19
`define GSP_TAD_BASE 7'h40
`define GSP_LAD_BASE 7'h20
// ********************************************
// interface states
// ********************************************
`define GSP_ST_IDLE 2'h0
`define GSP_ST_TALK 2'h1
`define GSP_ST_POLL 2'h2
`define GSP_ST_PTALK 2'h3
// ********************************************
// timing
// ********************************************
`define GSP_CLK_MHZ 200
`define GSP_CTL_HOLD_US 350
// 350 us at 200 MHz, sized to the hold counter so nothing is cut silently
`define GSP_CTL_HOLD_CYC 17'h11170
`define GSP_CNT_W 17
`endif

// ---- hw/gsp_sync.v ----
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module gsp_sync
#(
   parameter W = 1
)
(
   ref_clk,
   srst,
   d_in,
   q_out
);
   input wire ref_clk;
   input wire srst;
   input wire [W-1:0] d_in;
   output wire [W-1:0] q_out;

   reg [W-1:0] meta_r; // first stage, read only by second stage
   reg [W-1:0] sync_r; // second stage, safe to use

   // ********************************************
   // double register
   // ********************************************
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end
      else
      begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end

   assign q_out = sync_r;
endmodule

// ---- hw/gsp_talker.v ----
// bus talker and serial poll responder, peripheral side of the bus
`timescale 1ns/10ps
`include "gsp_regs.vh"
module gsp_talker
(
   ref_clk,
   srst,
   my_addr,
   atn_n_i,
   ifc_n_i,
   dav_n_i,
   nrfd_n_i,
   ndac_n_i,
   dio_n_i,
   send_request,
   service_request,
   end_request,
   periph_data,
   dav_n_o,
   dav_n_oe,
   ndac_n_o,
   ndac_n_oe,
   nrfd_n_o,
   nrfd_n_oe,
   dio_n_o,
   dio_n_oe,
   srq_n_o,
   srq_n_oe,
   eoi_n_o,
   eoi_n_oe,
   talk_enable,
   poll_in_progress,
   byte_transferred
);
   input wire ref_clk;
   input wire srst;
   input wire [4:0] my_addr; // primary address, strapped
   input wire atn_n_i; // bus attention, active low
   input wire ifc_n_i; // bus interface clear, active low
   input wire dav_n_i; // data valid from bus
   input wire nrfd_n_i; // not ready for data from bus
   input wire ndac_n_i; // not data accepted from bus
   input wire [7:0] dio_n_i; // bus data lines, active low
   input wire send_request; // peripheral byte ready
   input wire service_request; // peripheral wants service
   input wire end_request; // peripheral asks to end transfer
   input wire [7:0] periph_data; // peripheral output bus d1-d8
   output reg dav_n_o;
   output reg dav_n_oe;
   output reg ndac_n_o;
   output reg ndac_n_oe;
   output reg nrfd_n_o;
   output reg nrfd_n_oe;
   output reg [7:0] dio_n_o;
   output reg dio_n_oe;
   output reg srq_n_o;
   output reg srq_n_oe;
   output reg eoi_n_o;
   output reg eoi_n_oe;
   output reg talk_enable;
   output reg poll_in_progress;
   output reg byte_transferred;

   // ********************************************
   // input synchronisation
   // ********************************************
   wire [23:0] raw_in; // all asynchronous inputs in one bundle
   wire [23:0] syn_in; // same, two flops later
   wire atn_s;
   wire ifc_s;
   wire dav_s;
   wire nrfd_s;
   wire ndac_s;
   wire [7:0] dio_s;
   wire send_s;
   wire svc_s;
   wire endr_s;
   wire [7:0] pdat_s; // peripheral byte, same delay as its send request

   assign raw_in = {periph_data, ~atn_n_i, ~ifc_n_i, ~dav_n_i, nrfd_n_i, ndac_n_i, ~dio_n_i,
                    send_request, service_request, end_request};

   gsp_sync #(.W(24)) u_sync
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .d_in(raw_in),
      .q_out(syn_in)
   );

   assign pdat_s = syn_in[23:16];
   assign atn_s = syn_in[15]; // high when attention active
   assign ifc_s = syn_in[14]; // high when clear active
   assign dav_s = syn_in[13]; // high when data valid
   assign nrfd_s = syn_in[12]; // high when listeners ready
   assign ndac_s = syn_in[11]; // high when all accepted
   assign dio_s = syn_in[10:3];
   assign send_s = syn_in[2];
   assign svc_s = syn_in[1];
   assign endr_s = syn_in[0];

   // ********************************************
   // command decode helpers
   // ********************************************
   function is_cmd;
      input [6:0] byte_in;
      input [6:0] code;
      begin
         is_cmd = (byte_in == code);
      end
   endfunction

   reg [1:0] state_r; // remembered interface state
   reg [1:0] state_nxt;
   reg dav_prev_r; // edge detect on bus data valid
   reg acc_r; // command byte accepted, hold ndac high till dav drops
   reg drive_dav_r; // own data valid asserted
   reg gone_pend_r; // dav just let go, peripheral is told next cycle
   reg [`GSP_CNT_W-1:0] hold_r; // end prompt hold counter

   wire cmd_stb; // one pulse per command byte
   wire talking; // talk allowed on the bus
   wire [6:0] cmd;

   assign cmd = dio_s[6:0];
   assign cmd_stb = atn_s & dav_s & ~dav_prev_r;
   assign talking = (state_r == `GSP_ST_TALK || state_r == `GSP_ST_PTALK) & ~atn_s;

   // ********************************************
   // state memory, updated on each command byte
   // ********************************************
   always @*
   begin
      state_nxt = state_r;
      if (cmd_stb)
      begin
         // own talk address; keeps poll flavour if polling
         if (is_cmd(cmd, `GSP_TAD_BASE | {2'h0, my_addr}))
         begin
            if (state_r == `GSP_ST_POLL || state_r == `GSP_ST_PTALK)
               state_nxt = `GSP_ST_PTALK;
            else
               state_nxt = `GSP_ST_TALK;
         end
         // another talk address acts as untalk
         else if (cmd[6:5] == 2'h2 || is_cmd(cmd, `GSP_CMD_UNT))
         begin
            if (state_r == `GSP_ST_PTALK)
               state_nxt = `GSP_ST_POLL;
            else if (state_r == `GSP_ST_TALK)
               state_nxt = `GSP_ST_IDLE;
         end
         else if (is_cmd(cmd, `GSP_CMD_SPE))
         begin
            if (state_r == `GSP_ST_IDLE)
               state_nxt = `GSP_ST_POLL;
         end
         else if (is_cmd(cmd, `GSP_CMD_SPD))
            state_nxt = `GSP_ST_IDLE;
      end
   end

   // ********************************************
   // state register and command acceptance
   // ********************************************
   always @(posedge ref_clk)
   begin
      if (srst || ifc_s)
      begin
         state_r <= `GSP_ST_IDLE;
         dav_prev_r <= 1'b0;
         acc_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         dav_prev_r <= dav_s;
         // accept commands at once, regardless of the peripheral
         if (cmd_stb)
            acc_r <= 1'b1;
         else if (~dav_s)
            acc_r <= 1'b0;
      end
   end

   // ********************************************
   // talk handshake and peripheral strobes
   // ********************************************
   always @(posedge ref_clk)
   begin
      // one-cycle mark, set below only when dav is let go
      gone_pend_r <= 1'b0;
      if (srst || ifc_s)
      begin
         drive_dav_r <= 1'b0;
         byte_transferred <= 1'b0;
      end
      else if (~talking)
      begin
         // send request has no effect under attention
         drive_dav_r <= 1'b0;
         byte_transferred <= 1'b0;
      end
      else if (~drive_dav_r)
      begin
         // dav is already high on the bus when the peripheral hears
         if (gone_pend_r)
            byte_transferred <= 1'b1;
         // wait for the peripheral to drop send before a new byte
         else if (byte_transferred && ~send_s)
            byte_transferred <= 1'b0;
         else if (~byte_transferred && nrfd_s && send_s)
            drive_dav_r <= 1'b1;
      end
      else if (ndac_s)
      begin
         drive_dav_r <= 1'b0;
         gone_pend_r <= 1'b1;
      end
   end

   // ********************************************
   // end prompt timer, long enough for the controller to see it
   // ********************************************
   always @(posedge ref_clk)
   begin
      if (srst || ~talking)
         hold_r <= {`GSP_CNT_W{1'b0}};
      else if (endr_s && hold_r == {`GSP_CNT_W{1'b0}})
         hold_r <= `GSP_CTL_HOLD_CYC;
      else if (hold_r != {`GSP_CNT_W{1'b0}})
         hold_r <= hold_r - {{(`GSP_CNT_W-1){1'b0}}, 1'b1};
   end

   // ********************************************
   // registered pin and peripheral outputs
   // ********************************************
   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         dav_n_o <= 1'b1;
         dav_n_oe <= 1'b0;
         ndac_n_o <= 1'b1;
         ndac_n_oe <= 1'b0;
         nrfd_n_o <= 1'b1;
         nrfd_n_oe <= 1'b0;
         dio_n_o <= 8'hff;
         dio_n_oe <= 1'b0;
         srq_n_o <= 1'b1;
         srq_n_oe <= 1'b0;
         eoi_n_o <= 1'b1;
         eoi_n_oe <= 1'b0;
         talk_enable <= 1'b0;
         poll_in_progress <= 1'b0;
      end
      else
      begin
         // data drivers only while talking, never in bare poll
         talk_enable <= talking;
         dio_n_oe <= talking;
         dio_n_o <= ~pdat_s;
         dav_n_oe <= talking;
         dav_n_o <= ~drive_dav_r;
         // under attention hold ndac low until the command is taken
         ndac_n_oe <= atn_s & ~acc_r;
         ndac_n_o <= 1'b0;
         nrfd_n_oe <= 1'b0;
         nrfd_n_o <= 1'b1;
         srq_n_oe <= svc_s | (hold_r != {`GSP_CNT_W{1'b0}});
         srq_n_o <= 1'b0;
         eoi_n_oe <= talking & endr_s;
         eoi_n_o <= 1'b0;
         poll_in_progress <= (state_r == `GSP_ST_POLL || state_r == `GSP_ST_PTALK);
      end
   end
endmodule

// ---- verification/gsp_props.sv ----
// checker for the talker and serial poll block
`timescale 1ns/10ps
module gsp_props
(
   input wire ref_clk,
   input wire srst,
   input wire atn_n_i,
   input wire ifc_n_i,
   input wire service_request,
   input wire dav_n_o,
   input wire dio_n_oe,
   input wire srq_n_oe,
   input wire talk_enable,
   input wire poll_in_progress,
   input wire byte_transferred
);
   // one clock domain, reset gates every check
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // inputs pass two flops, so answers carry a few cycles of slack
   srq_set_a: assert property ($rose(service_request) |-> ##[1:5] srq_n_oe)
      else $error("srq not pulled");
   srq_drop_a: assert property ($fell(service_request) |-> ##[1:5] !srq_n_oe)
      else $error("srq not released");
   dav_talk_a: assert property ($fell(dav_n_o) |-> talk_enable)
      else $error("dav low outside talk");
   gone_dav_a: assert property ($rose(byte_transferred) |-> dav_n_o)
      else $error("byte gone with dav low");
   ifc_idle_a: assert property (!ifc_n_i [*6] |-> !talk_enable && !poll_in_progress)
      else $error("clear did not idle");
   poll_quiet_a: assert property (poll_in_progress && !talk_enable |-> !dio_n_oe)
      else $error("status byte driven early");
   atn_quiet_a: assert property (!atn_n_i [*5] |-> !talk_enable)
      else $error("talking under attention");
   talk_atn_a: assert property ($rose(talk_enable) |-> atn_n_i)
      else $error("talk began under attention");
   poll_atn_a: assert property ($rose(poll_in_progress) |-> !atn_n_i)
      else $error("poll set without command");
endmodule
bind gsp_talker gsp_props u_props (.ref_clk, .srst, .atn_n_i, .ifc_n_i, .service_request,
   .dav_n_o, .dio_n_oe, .srq_n_oe, .talk_enable, .poll_in_progress, .byte_transferred);

// ---- verification/gsp_ctl_model.sv ----
// bus controller and listener model facing the talker
`timescale 1ns/10ps
module gsp_ctl_model
(
   input wire ref_clk,
   input wire dav_w,
   input wire ndac_w,
   input wire [7:0] dio_w,
   output reg atn_n,
   output reg m_dav_n,
   output reg m_ndac_n,
   output reg m_nrfd_n,
   output reg [7:0] m_dio_n,
   output reg [7:0] got
);
   initial
   begin
      atn_n = 1'b1;
      m_dav_n = 1'b1;
      m_ndac_n = 1'b1;
      m_nrfd_n = 1'b1;
      m_dio_n = 8'hff;
      got = 8'h00;
   end
   // listener role; lines released under attention so commands flow
   always @(negedge ref_clk)
   begin
      if (!atn_n)
      begin
         m_ndac_n <= 1'b1;
         m_nrfd_n <= 1'b1;
      end
      else if (!dav_w)
      begin
         got <= ~dio_w; // byte taken while valid
         m_nrfd_n <= 1'b0;
         m_ndac_n <= 1'b1;
      end
      else
      begin
         m_nrfd_n <= 1'b1;
         m_ndac_n <= 1'b0;
      end
   end
   // one command byte, held until accepted, then lines float high
   task cmd(input [7:0] c);
      integer i;
      begin
         @(negedge ref_clk);
         atn_n <= 1'b0;
         m_dio_n <= ~c;
         repeat (5) @(negedge ref_clk);
         m_dav_n <= 1'b0;
         for (i = 0; i < 40 && ndac_w !== 1'b1; i = i + 1) @(negedge ref_clk);
         m_dav_n <= 1'b1;
         m_dio_n <= 8'hff;
         for (i = 0; i < 40 && ndac_w !== 1'b0; i = i + 1) @(negedge ref_clk);
      end
   endtask
   task rel;
      begin
         @(negedge ref_clk);
         atn_n <= 1'b1;
      end
   endtask
endmodule

// ---- verification/gsp_tb.sv ----
// self-checking bench for the talker and serial poll block
`timescale 1ns/10ps
`include "gsp_regs.vh"
module tb;
   localparam [7:0] tad = {1'b0, `GSP_TAD_BASE} | 8'h07;
   reg ref_clk = 1'b0;
   reg srst = 1'b1;
   reg ifc_n = 1'b1;
   reg send_request = 1'b0;
   reg service_request = 1'b0;
   reg end_request = 1'b0;
   reg [7:0] periph_data = 8'h00;
   integer miscompares = 0;
   integer tests_run = 0;
   integer cyc = 0;
   wire atn_n, m_dav_n, m_ndac_n, m_nrfd_n, dav_n_o, dav_n_oe, ndac_n_o, ndac_n_oe;
   wire nrfd_n_o, nrfd_n_oe, dio_n_oe, srq_n_o, srq_n_oe;
   wire talk_enable, poll_in_progress, byte_transferred, eoi_n_o, eoi_n_oe;
   wire [7:0] m_dio_n, got, dio_n_o;
   // wired-and bus, an undriven line sits at the pull-up level
   wire dav_w = (dav_n_oe ? dav_n_o : 1'b1) & m_dav_n;
   wire ndac_w = (ndac_n_oe ? ndac_n_o : 1'b1) & m_ndac_n;
   wire nrfd_w = (nrfd_n_oe ? nrfd_n_o : 1'b1) & m_nrfd_n;
   wire [7:0] dio_w = (dio_n_oe ? dio_n_o : 8'hff) & m_dio_n;
   wire srq_w = srq_n_oe ? srq_n_o : 1'b1;
   always #2.5 ref_clk = ~ref_clk;
   gsp_talker u_dut (.ref_clk, .srst, .my_addr(5'h07), .atn_n_i(atn_n), .ifc_n_i(ifc_n),
      .dav_n_i(dav_w), .nrfd_n_i(nrfd_w), .ndac_n_i(ndac_w), .dio_n_i(dio_w), .send_request,
      .service_request, .end_request, .periph_data, .dav_n_o, .dav_n_oe, .ndac_n_o,
      .ndac_n_oe, .nrfd_n_o, .nrfd_n_oe, .dio_n_o, .dio_n_oe, .srq_n_o, .srq_n_oe,
      .eoi_n_o, .eoi_n_oe, .talk_enable, .poll_in_progress, .byte_transferred);
   gsp_ctl_model u_ctl (.ref_clk, .dav_w, .ndac_w, .dio_w, .atn_n, .m_dav_n, .m_ndac_n,
      .m_nrfd_n, .m_dio_n, .got);
   // ********************************************
   // helpers
   // ********************************************
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp)
         begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task chk1(input seen, input exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask
   // command bytes then attention off, time for the sync flops
   task go(input [7:0] a, input [7:0] b);
      begin
         u_ctl.cmd(a);
         if (b !== a) u_ctl.cmd(b);
         u_ctl.rel;
         repeat (6) @(negedge ref_clk);
      end
   endtask
   // bounded wait, a dead handshake cannot hang the run
   task wait_bt(input v);
      integer i;
      for (i = 0; i < 60 && byte_transferred !== v; i = i + 1) @(negedge ref_clk);
   endtask
   // one peripheral byte: settle, request, gone, withdraw
   task xfer(input [7:0] d);
      begin
         periph_data = d;
         repeat (2) @(negedge ref_clk);
         send_request = 1'b1;
         wait_bt(1'b1);
         chk1(byte_transferred, 1'b1);
         chk(got, d);
         send_request = 1'b0;
         wait_bt(1'b0);
         chk1(byte_transferred, 1'b0);
      end
   endtask
   // ********************************************
   // scenarios
   // ********************************************
   task t_talk;
      begin
         go(tad, tad);
         chk1(talk_enable, 1'b1);
         xfer(8'h5a);
         xfer(8'ha5);
         go(tad + 8'h01, tad + 8'h01);
         chk1(talk_enable, 1'b0);
         go(tad, tad);
         chk1(talk_enable, 1'b1);
         go({1'b0, `GSP_CMD_UNT}, {1'b0, `GSP_CMD_UNT});
         chk1(talk_enable, 1'b0);
         $display("talk test done");
      end
   endtask
   task t_poll;
      begin
         service_request = 1'b1;
         repeat (5) @(negedge ref_clk);
         chk1(srq_w, 1'b0);
         periph_data = 8'h41; // status with the service bit set
         go({1'b0, `GSP_CMD_UNL}, {1'b0, `GSP_CMD_SPE});
         chk1(poll_in_progress, 1'b1);
         chk1(dio_n_oe, 1'b0);
         go(tad, tad);
         chk1(talk_enable, 1'b1);
         xfer(8'h41);
         service_request = 1'b0;
         repeat (5) @(negedge ref_clk);
         chk1(srq_w, 1'b1);
         go({1'b0, `GSP_CMD_UNT}, {1'b0, `GSP_CMD_SPD});
         chk1(poll_in_progress, 1'b0);
         $display("poll test done");
      end
   endtask
   // status without the service bit, controller moves to the next device
   task t_next;
      begin
         periph_data = 8'h01;
         go({1'b0, `GSP_CMD_UNL}, {1'b0, `GSP_CMD_SPE});
         go(tad, tad);
         chk1(talk_enable, 1'b1);
         xfer(8'h01);
         go(tad + 8'h01, tad + 8'h01);
         chk1(talk_enable, 1'b0);
         chk1(poll_in_progress, 1'b1);
         go({1'b0, `GSP_CMD_UNT}, {1'b0, `GSP_CMD_SPD});
         chk1(poll_in_progress, 1'b0);
         $display("next device test done");
      end
   endtask
   // peripheral prompts the end of a talk; srq must outlast the request
   task t_end;
      begin
         go(tad, tad);
         end_request = 1'b1;
         repeat (5) @(negedge ref_clk);
         chk1(srq_w, 1'b0);
         chk1(eoi_n_oe, 1'b1);
         chk1(eoi_n_o, 1'b0);
         end_request = 1'b0;
         repeat (200) @(negedge ref_clk);
         chk1(srq_w, 1'b0);
         chk1(eoi_n_oe, 1'b0);
         go({1'b0, `GSP_CMD_UNT}, {1'b0, `GSP_CMD_UNT});
         chk1(talk_enable, 1'b0);
         chk1(srq_w, 1'b1);
         $display("end prompt test done");
      end
   endtask
   task t_ifc;
      begin
         go(tad, tad);
         chk1(talk_enable, 1'b1);
         ifc_n = 1'b0;
         repeat (8) @(negedge ref_clk);
         ifc_n = 1'b1;
         repeat (6) @(negedge ref_clk);
         chk1(talk_enable, 1'b0);
         $display("clear test done");
      end
   endtask
   task end_of_test;
      begin
         $display("compares %0d mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial
   begin
      repeat (4) @(negedge ref_clk);
      srst = 1'b0;
      t_talk;
      t_poll;
      t_next;
      t_end;
      t_ifc;
      end_of_test;
   end
   // hang guard, far above the several hundred cycles the tests need
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 8000)
      begin
         miscompares = miscompares + 1;
         end_of_test;
      end
   end
endmodule
